//--- rtl/pbg_defines.svh
// Functional notes
// - Direction and data registers decode at fixed spots on address bits 17:2.
// - Direction bit 1 makes a pin output, 0 makes it input.
// - Direction register is write-only and always reads back all ones.
// - Direction register clears to zero on reset and in hardware standby.
// - Software standby keeps direction, so output pins keep driving.
// - With direction 1 a port read returns the stored latch bit.
// - With direction 0 a port read returns the sampled pin level.
// - Latch clears on reset and hardware standby; holds in software standby.
// - Pin 7: input, latch output, or pattern output 15 by pattern bit 15.
// - Pin 7 feeds DMA channel-1 request on class 1, ADC trigger when enabled.
// - DMA class 1 from select-bit combinations; otherwise class 2.
// - Pin 6: input, latch or pattern 14; feeds DMA channel-0 on class 1.
// - Pin 5 drives compare output B when combined mode and enable both 1.
// - Pin 4 drives compare output A when combined mode and enable both 1.
// - Pin 3 is capture input B when combined and PWM are 0, top I/O bit 1.
`ifndef PBG_DEFINES_SVH
`define PBG_DEFINES_SVH

// Register indices; byte address is four times the index
`define PBG_IDX_DIRECTION 16'hFFD4
`define PBG_IDX_DATA      16'hFFD6

`define PBG_PORT_W        8
`define PBG_RST_DIRECTION 8'h00
`define PBG_RST_LATCH     8'h00
`define PBG_DIR_READBACK  8'hFF

// Field positions in a DMA select vector {a2,a1,a0,b2,b1}
`define PBG_SEL_A2 4
`define PBG_SEL_A1 3
`define PBG_SEL_A0 2
`define PBG_SEL_B2 1
`define PBG_SEL_B1 0

// Pin positions
`define PBG_PIN_DMA1 7
`define PBG_PIN_DMA0 6
`define PBG_PIN_CMPB 5
`define PBG_PIN_CMPA 4
`define PBG_PIN_CAPB 3

`endif

//--- rtl/pbg_pkg.sv
`include "pbg_defines.svh"

package pbg_pkg;

  typedef struct packed {
    logic [`PBG_PORT_W-1:0] dir;
    logic [`PBG_PORT_W-1:0] latch;
    logic [`PBG_PORT_W-1:0] pin_out;
    logic [`PBG_PORT_W-1:0] pin_oe;
    logic                   dma_req1_n;
    logic                   dma_req0_n;
    logic                   adc_trig_n;
    logic                   cap_b;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } pbg_state_t;

  typedef logic [4:0] pbg_dma_sel_t;

endpackage : pbg_pkg

//--- rtl/pbg_pin_sync.sv
`timescale 1ns/1ps

// Three-stage pin sampler; a level counts once stages two and three agree
module pbg_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pbg_sync_t;

  pbg_sync_t sync_q;
  pbg_sync_t sync_d;
  logic [W-1:0] agree;

  always_comb
  begin
    sync_d     = sync_q;
    agree      = ~(sync_q.s2 ^ sync_q.s3);
    sync_d.s1  = pin;
    sync_d.s2  = sync_q.s1;
    sync_d.s3  = sync_q.s2;
    sync_d.lvl = (agree & sync_q.s3) | (~agree & sync_q.lvl);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= '0;
    else
      sync_q <= sync_d;
  end

  assign level = sync_q.lvl;

endmodule : pbg_pin_sync

//--- rtl/pbg_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "pbg_defines.svh"

module pbg_top
  import pbg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Power states
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // Package pins
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  // Timing pattern unit
  input  wire logic [7:0]  pattern_enable_upper,
  input  wire logic [7:0]  pattern_out,
  // DMA unit
  input  wire logic [4:0]  dma_ch1_select,
  input  wire logic [4:0]  dma_ch0_select,
  output logic             dma_request_ch1_n,
  output logic             dma_request_ch0_n,
  // A/D converter
  input  wire logic        adc_external_trigger_enable,
  output logic             adc_trigger_in_n,
  // Integrated timer unit
  input  wire logic        combined_mode_bit,
  input  wire logic        compare_out_a_enable,
  input  wire logic        compare_out_b_enable,
  input  wire logic        compare_output_a,
  input  wire logic        compare_output_b,
  input  wire logic        ch4_pwm_select,
  input  wire logic        io_control_b_top,
  output logic             ch4_capture_b
);

  localparam pbg_state_t ST_RST = '{
    dir:     `PBG_RST_DIRECTION,
    latch:   `PBG_RST_LATCH,
    pin_out: 8'h00,
    pin_oe:  8'h00,
    dma_req1_n: 1'b1,
    dma_req0_n: 1'b1,
    adc_trig_n: 1'b1,
    cap_b:   1'b0,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

  pbg_state_t  state_q;
  pbg_state_t  state_d;
  logic [7:0]  pin_level;
  logic        hit_dir;
  logic        hit_dat;
  logic        acc_start;
  logic        wr_done;
  logic [7:0]  port_read;
  logic [1:0]  mux_b5;
  logic [1:0]  mux_b4;

  pbg_pin_sync #(
    .W (8)
  ) pbg_pin_sync_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pb_in),
    .level   (pin_level)
  );

  // DMA setting class 1 from {a2,a1,a0,b2,b1}
  function automatic logic pbg_dma_class1(input pbg_dma_sel_t sel);
    logic pair;
    pair = sel[`PBG_SEL_A2] & sel[`PBG_SEL_A1];
    pbg_dma_class1 =
      (!pair & sel[`PBG_SEL_B2] & sel[`PBG_SEL_B1]) |
      (pair & !sel[`PBG_SEL_A0] & sel[`PBG_SEL_B2]) |
      (pair & sel[`PBG_SEL_A0] & sel[`PBG_SEL_B2] &
       sel[`PBG_SEL_B1]);
  endfunction : pbg_dma_class1

  // Plain port pin: returns {oe, out}
  function automatic logic [1:0] pbg_gpio(
    input logic dir,
    input logic pe,
    input logic tp,
    input logic lat
  );
    pbg_gpio = {dir, (pe ? tp : lat)};
  endfunction : pbg_gpio

  // Address decode matches the index on address bits 17:2 only
  assign hit_dir = (paddr[17:2] == `PBG_IDX_DIRECTION);
  assign hit_dat = (paddr[17:2] == `PBG_IDX_DATA);

  // Output pins read the latch, input pins read the sampled level
  assign port_read = (state_q.dir & state_q.latch) |
                     (~state_q.dir & pin_level);

  assign acc_start = psel & penable & ~state_q.pready;
  assign wr_done   = psel & penable & state_q.pready & pwrite & pstrb[0];

  // Timer compare outputs take the pin ahead of the latch
  assign mux_b5 = (combined_mode_bit & compare_out_b_enable) ?
                  {1'b1, compare_output_b} :
                  pbg_gpio(state_q.dir[5], pattern_enable_upper[5],
                           pattern_out[5], state_q.latch[5]);
  assign mux_b4 = (combined_mode_bit & compare_out_a_enable) ?
                  {1'b1, compare_output_a} :
                  pbg_gpio(state_q.dir[4], pattern_enable_upper[4],
                           pattern_out[4], state_q.latch[4]);

  always_comb
  begin
    state_d        = state_q;
    state_d.pready = 1'b0;

    // One wait state, then the answer
    if (acc_start)
    begin
      state_d.pready  = 1'b1;
      state_d.pslverr = !(hit_dir | hit_dat);
      state_d.prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit_dir)
          state_d.prdata = {24'h00_0000, `PBG_DIR_READBACK};
        else if (hit_dat)
          state_d.prdata = {24'h00_0000, port_read};
      end
    end

    // Writes land at the completing edge; held off in software standby
    if (wr_done && !sw_standby)
    begin
      if (hit_dir)
        state_d.dir = pwdata[7:0];
      else if (hit_dat)
        state_d.latch = pwdata[7:0];
    end

    if (hw_standby)
    begin
      state_d.dir   = `PBG_RST_DIRECTION;
      state_d.latch = `PBG_RST_LATCH;
    end

    // Pin drivers
    {state_d.pin_oe[7], state_d.pin_out[7]} =
      pbg_gpio(state_q.dir[7], pattern_enable_upper[7],
               pattern_out[7], state_q.latch[7]);
    {state_d.pin_oe[6], state_d.pin_out[6]} =
      pbg_gpio(state_q.dir[6], pattern_enable_upper[6],
               pattern_out[6], state_q.latch[6]);
    {state_d.pin_oe[5], state_d.pin_out[5]} = mux_b5;
    {state_d.pin_oe[4], state_d.pin_out[4]} = mux_b4;
    for (int i = 0; i < 4; i++)
    begin
      {state_d.pin_oe[i], state_d.pin_out[i]} =
        pbg_gpio(state_q.dir[i], pattern_enable_upper[i],
                 pattern_out[i], state_q.latch[i]);
    end

    // Pin levels handed to other units; idle level when not routed
    state_d.dma_req1_n = pbg_dma_class1(dma_ch1_select) ?
                         pin_level[`PBG_PIN_DMA1] : 1'b1;
    state_d.dma_req0_n = pbg_dma_class1(dma_ch0_select) ?
                         pin_level[`PBG_PIN_DMA0] : 1'b1;
    state_d.adc_trig_n = adc_external_trigger_enable ?
                         pin_level[`PBG_PIN_DMA1] : 1'b1;
    state_d.cap_b   = (!combined_mode_bit && !ch4_pwm_select &&
                       io_control_b_top) ?
                      pin_level[`PBG_PIN_CAPB] : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_RST;
    else
      state_q <= state_d;
  end

  assign pready            = state_q.pready;
  assign pslverr           = state_q.pslverr;
  assign prdata            = state_q.prdata;
  assign pb_out            = state_q.pin_out;
  assign pb_oe             = state_q.pin_oe;
  assign dma_request_ch1_n = state_q.dma_req1_n;
  assign dma_request_ch0_n = state_q.dma_req0_n;
  assign adc_trigger_in_n  = state_q.adc_trig_n;
  assign ch4_capture_b     = state_q.cap_b;

  // Checks
  logic rd_done;
  assign rd_done = psel & penable & state_q.pready & !pwrite;

  AST_DIR_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit_dir && !sw_standby && !hw_standby)
    |=> (state_q.dir == $past(pwdata[7:0])))
    else $error("direction write not stored");

  AST_DIR_OE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(combined_mode_bit && compare_out_b_enable)
    |=> (pb_oe[5] == $past(state_q.dir[5])))
    else $error("pin enable does not follow direction");

  AST_DIR_READ_ONES: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_done && hit_dir) |-> (prdata == 32'h0000_00FF && !pslverr))
    else $error("direction read not all ones");

  AST_HW_STANDBY_CLEAR: assert property (
    @(posedge pclk) disable iff (!presetn)
    hw_standby |=> (state_q.dir == 8'h00 && state_q.latch == 8'h00))
    else $error("hardware standby did not clear");

  AST_SW_STANDBY_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sw_standby && !hw_standby) |=> $stable(state_q.dir) &&
    $stable(state_q.latch))
    else $error("software standby lost state");

  AST_READ_LATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_done && hit_dat) |->
    ((prdata[7:0] & state_q.dir) == (state_q.latch & state_q.dir)))
    else $error("output pin read not from latch");

  AST_READ_PIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_done && hit_dat && $stable(state_q.dir)) |->
    ((prdata[7:0] & ~state_q.dir) ==
     ($past(pin_level) & ~state_q.dir)))
    else $error("input pin read not from pin");

  AST_PIN7_PATTERN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q.dir[7] && pattern_enable_upper[7])
    |=> (pb_oe[7] && pb_out[7] == $past(pattern_out[7])))
    else $error("pin 7 pattern output wrong");

  AST_DMA1_ROUTE: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (dma_request_ch1_n ==
              (pbg_dma_class1($past(dma_ch1_select)) ?
               $past(pin_level[7]) : 1'b1)))
    else $error("channel 1 request routing wrong");

  AST_DMA_CLASS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dma_ch0_select == 5'h1E) |=> dma_request_ch0_n)
    else $error("class 2 select must not route pin");

  AST_DMA0_ROUTE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dma_ch0_select == 5'h03 && !pin_level[6]) |=> !dma_request_ch0_n)
    else $error("channel 0 request not routed");

  AST_CMPB_PRIO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (combined_mode_bit && compare_out_b_enable)
    |=> (pb_oe[5] && pb_out[5] == $past(compare_output_b)))
    else $error("compare B does not own pin 5");

  AST_CMPA_PRIO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (combined_mode_bit && compare_out_a_enable)
    |=> (pb_oe[4] && pb_out[4] == $past(compare_output_a)))
    else $error("compare A does not own pin 4");

  AST_CAPB: assert property (
    @(posedge pclk) disable iff (!presetn)
    (combined_mode_bit || ch4_pwm_select || !io_control_b_top)
    |=> !ch4_capture_b)
    else $error("capture B passed while not selected");

  AST_LATCH_YIELDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (combined_mode_bit && compare_out_a_enable &&
     !state_q.dir[4]) |=> pb_oe[4])
    else $error("alternate output did not win");

  AST_LATCH_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit_dat && !sw_standby && !hw_standby)
    |=> (state_q.latch == $past(pwdata[7:0])))
    else $error("data write not stored");

  AST_UNMAPPED_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready) |-> (pslverr == !(hit_dir || hit_dat)))
    else $error("error response does not match decode");

  AST_SW_STANDBY_DRIVE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sw_standby && !hw_standby && !combined_mode_bit)
    |=> (pb_oe == $past(state_q.dir)))
    else $error("software standby changed pin drive");

  AST_PIN7_LATCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q.dir[7] && !pattern_enable_upper[7])
    |=> (pb_oe[7] && pb_out[7] == $past(state_q.latch[7])))
    else $error("pin 7 latch output wrong");

  AST_PIN6_PATTERN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_q.dir[6] && pattern_enable_upper[6])
    |=> (pb_oe[6] && pb_out[6] == $past(pattern_out[6])))
    else $error("pin 6 pattern output wrong");

  AST_ADC_ROUTE: assert property (
    @(posedge pclk) disable iff (!presetn)
    adc_external_trigger_enable |=>
    (adc_trigger_in_n == $past(pin_level[`PBG_PIN_DMA1])))
    else $error("trigger input not routed");

  CVR_DATA_READ: cover property (
    @(posedge pclk) disable iff (!presetn)
    rd_done && hit_dat && state_q.dir != 8'h00);

  CVR_DIR_WRITE: cover property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit_dir);

  CVR_CMPB_OWN: cover property (
    @(posedge pclk) disable iff (!presetn)
    combined_mode_bit && compare_out_b_enable ##1 pb_oe[5]);

  CVR_DMA1_REQ: cover property (
    @(posedge pclk) disable iff (!presetn)
    !dma_request_ch1_n);

endmodule : pbg_top

//--- tb/pbg_pin_partner.sv
`timescale 1ns/1ps

// Pad model: a driven pin shows the port value, an input pin the outside level
module pbg_pin_partner (
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pb_in
);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_level);
endmodule : pbg_pin_partner

//--- tb/tb_pbg_top.sv
`timescale 1ns/1ps

module tb_pbg_top;
  import pbg_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, hw_sb = 0, sw_sb = 0;
  logic [7:0]  pb_in, pb_out, pb_oe, ext = 8'h5A, peu = 0, pto = 0;
  logic [4:0]  s1 = 0, s0 = 0;
  logic        trg = 0, cmb = 0, ena = 0, enb = 0, coa = 0, cob = 0;
  logic        pwm = 0, iob = 0, rq1_n, rq0_n, adc_n, capb;
  logic [31:0] rd;
  logic        er;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  localparam logic [31:0] DIR_A = 32'h0003FF50, DAT_A = 32'h0003FF58;

  always #20 pclk = ~pclk;

  pbg_pin_partner pbg_pin_partner_inst (.pb_out(pb_out), .pb_oe(pb_oe),
    .ext_level(ext), .pb_in(pb_in));

  pbg_top pbg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .hw_standby(hw_sb), .sw_standby(sw_sb), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pattern_enable_upper(peu),
    .pattern_out(pto), .dma_ch1_select(s1), .dma_ch0_select(s0),
    .dma_request_ch1_n(rq1_n), .dma_request_ch0_n(rq0_n),
    .adc_external_trigger_enable(trg), .adc_trigger_in_n(adc_n),
    .combined_mode_bit(cmb), .compare_out_a_enable(ena),
    .compare_out_b_enable(enb), .compare_output_a(coa),
    .compare_output_b(cob), .ch4_pwm_select(pwm),
    .io_control_b_top(iob), .ch4_capture_b(capb));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic t_reset;
    apb(0, DIR_A, 0);
    chk(rd, 32'h000000FF);
    apb(0, DAT_A, 0);
    chk(rd, 32'h0000005A);
    chk(pb_oe, 8'h00);
  endtask : t_reset

  task automatic t_rw;
    apb(1, DIR_A, 32'h000000F0);
    apb(1, DAT_A, 32'h000000A5);
    apb(0, DAT_A, 0);
    chk(rd, 32'h000000AA);
    chk(pb_oe, 8'hF0);
    chk(pb_out & pb_oe, 8'hA0);
    apb(0, 32'h0003FF54, 0);
    chk(er, 1'b1);
    apb(1, 32'h00C3FF58, 32'h0000005C);
    apb(0, DAT_A, 0);
    chk(rd, 32'h0000005A);
    chk(er, 1'b0);
    pstrb <= 4'hE;
    apb(1, DAT_A, 32'h000000FF);
    pstrb <= 4'hF;
    apb(0, DAT_A, 0);
    chk(rd, 32'h0000005A);
  endtask : t_rw

  task automatic t_pat;
    peu <= 8'hC0;
    pto <= 8'h80;
    tick(3);
    chk(pb_out[7:6], 2'b10);
    peu <= 0;
  endtask : t_pat

  task automatic t_cmp;
    apb(1, DIR_A, 0);
    cmb <= 1;
    ena <= 1;
    enb <= 1;
    cob <= 1;
    tick(3);
    chk({pb_oe[5:4], pb_out[5:4]}, 4'hE);
    enb <= 0;
    tick(3);
    chk(pb_oe[5:4], 2'b01);
    ena <= 0;
    enb <= 1;
    tick(3);
    chk(pb_oe[5:4], 2'b10);
    cmb <= 0;
    tick(3);
    chk(pb_oe, 8'h00);
  endtask : t_cmp

  function automatic logic cls1(input logic [4:0] s);
    return (!(s[4] & s[3]) && s[1] && s[0]) ||
           (s[4] && s[3] && !s[2] && s[1]) || (&s);
  endfunction : cls1

  task automatic t_dma;
    ext <= 8'h3A;
    tick(6);
    for (int i = 0; i < 32; i++)
    begin
      s1 <= i[4:0];
      s0 <= ~i[4:0];
      trg <= i[0];
      tick(3);
      chk(rq1_n, !cls1(i[4:0]));
      chk(rq0_n, !cls1(~i[4:0]));
      chk(adc_n, !i[0]);
    end
    ext <= 8'h5A;
  endtask : t_dma

  task automatic t_cap;
    iob <= 1;
    tick(6);
    chk(capb, 1'b1);
    pwm <= 1;
    tick(3);
    chk(capb, 1'b0);
    pwm <= 0;
    cmb <= 1;
    tick(3);
    chk(capb, 1'b0);
    cmb <= 0;
  endtask : t_cap

  task automatic t_stby;
    apb(1, DIR_A, 32'h0000000F);
    apb(1, DAT_A, 32'h00000033);
    sw_sb <= 1;
    apb(1, DIR_A, 32'h000000F0);
    apb(1, DAT_A, 32'h000000CC);
    tick(2);
    chk({pb_oe, pb_out & pb_oe}, 16'h0F03);
    apb(0, DAT_A, 0);
    chk(rd, 32'h00000053);
    sw_sb <= 0;
    hw_sb <= 1;
    tick(2);
    hw_sb <= 0;
    tick(2);
    chk(pb_oe, 8'h00);
    apb(0, DAT_A, 0);
    chk(rd, 32'h0000005A);
  endtask : t_stby

  initial
  begin
    tick(8);
    presetn <= 1;
    tick(6);
    t_reset();
    t_rw();
    t_pat();
    t_cmp();
    t_dma();
    t_cap();
    t_stby();
    close_out();
  end
endmodule : tb_pbg_top
